/* ocm_pkg.sv */
// package: constants for the oscillator mode and internal clock block
package ocm_pkg;

  // register indices, no printed offsets
  localparam logic [3:0] OCM_ADDR_TRIM   = 4'h0;
  localparam logic [3:0] OCM_ADDR_CTRL   = 4'h1;
  localparam logic [3:0] OCM_ADDR_STATUS = 4'h2;

  // reset values
  localparam logic [5:0] OCM_TRIM_RST = 6'h00;
  localparam logic [2:0] OCM_FSEL_RST = 3'h0;

  // field width and positions
  localparam int OCM_TRIM_W  = 6;
  localparam int OCM_FSEL_LO = 4;

  // clock mode config encodings
  localparam logic [3:0] OCM_MODE_LOW_POWER  = 4'h0;
  localparam logic [3:0] OCM_MODE_CRYSTAL    = 4'h1;
  localparam logic [3:0] OCM_MODE_HS_XTAL    = 4'h2;
  localparam logic [3:0] OCM_MODE_EXT_OUT    = 4'h4;
  localparam logic [3:0] OCM_MODE_MULT_XTAL  = 4'h6;
  localparam logic [3:0] OCM_MODE_RC_OUT     = 4'h7;
  localparam logic [3:0] OCM_MODE_INT_DUAL   = 4'h8;
  localparam logic [3:0] OCM_MODE_INT_CKOUT  = 4'h9;
  localparam logic [3:0] OCM_MODE_RC_IO      = 4'hc;
  localparam logic [3:0] OCM_MODE_EXT_IO     = 4'hd;

  // frequency select encodings
  localparam logic [2:0] OCM_FSEL_FAST = 3'h7;
  localparam logic [2:0] OCM_FSEL_SLOW = 3'h0;

  // limits and settle times
  localparam int OCM_MULT_FACTOR     = 4;
  localparam int OCM_MULT_REF_MAX_KHZ = 10000;
  localparam int OCM_CORE_MAX_KHZ    = 40000;
  localparam int OCM_SLOW_SETTLE_CYC = 8;
  localparam int OCM_FAST_SETTLE_US  = 1000;
  localparam int OCM_CLK_KHZ         = 40000;
  localparam int OCM_FAST_SETTLE_CYC = OCM_FAST_SETTLE_US * OCM_CLK_KHZ / 1000;

endpackage : ocm_pkg

/* ocm_div4.sv */
// divide-by-four clock-out generator
`timescale 1ns/1ps
`default_nettype none
module ocm_div4
  import ocm_pkg::*;
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  // control
  input  wire logic i_enable,
  // output
  output logic      o_clk_div4
);

  typedef struct packed {
    logic [1:0] count;
    logic       out;
  } ocm_div_state_type;

  ocm_div_state_type state;
  ocm_div_state_type next_state;

  // two-bit counter, msb is the 50 percent clock
  always_comb begin
    next_state = state;
    if (i_enable) begin
      next_state.count = state.count + 2'h1;
      next_state.out   = next_state.count[1];
    end else begin
      next_state.count = 2'h0;
      next_state.out   = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_clk_div4 = state.out;

  // output holds two cycles each level while enabled
  sequence two_low_s;
    i_enable && !o_clk_div4 ##1 i_enable && !o_clk_div4;
  endsequence
  duty_half_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    two_low_s ##1 i_enable |=> o_clk_div4)
    else $error("divider output not high after two low cycles");

endmodule : ocm_div4
`default_nettype wire

/* ocm_osc_ctrl.sv */
// oscillator mode decode, internal clock select, trim register and pin reuse
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - clock mode comes from four-bit config, latched once after power-on reset
// - multiplied crystal mode runs crystal oscillator with references up to 10 MHz
// - multiplied crystal mode makes internal clock four times reference, 40 MHz max
// - multiplier enabled only in multiplied crystal mode
// - high-speed crystal mode accepts external clock on input pin
// - external clock modes need no start-up wait after reset or sleep
// - external clock-out mode drives output pin with clock divided by four
// - external clock I/O mode gives output pin to port A bit 6
// - RC clock-out mode drives output pin with clock divided by four
// - RC I/O mode gives output pin to port A bit 6
// - fast 8 MHz source direct or postscaled 125 kHz to 4 MHz
// - fast source enabled whenever 125 kHz to 8 MHz selected in an internal clock mode
// - slow 31 kHz source on for internal clock or special features
// - frequency select field picks fast, slow or postscaled output
// - select 111 fast, 110..001 4 MHz..125 kHz, 000 slow
// - internal clock-out mode: output pin divided clock, input pin port bit 7
// - internal dual-I/O mode: input pin bit 7, output pin bit 6
// - trim settles in 8 slow cycles and 1 ms fast, execution continues
// - no flag reports that a trim shift has completed
// - six-bit trim is signed: zero centre, 011111 max, 100000 min
// - trim bits 7 and 6 read zero, trim resets to zero
module ocm_osc_ctrl
  import ocm_pkg::*;
#(
  parameter int FAST_SETTLE_CYC = OCM_FAST_SETTLE_CYC
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  // configuration and feature enables
  input  wire logic [3:0] i_clock_mode_config,
  input  wire logic       i_pwrup_timer_en,
  input  wire logic       i_failsafe_en,
  input  wire logic       i_watchdog_en,
  input  wire logic       i_two_speed_en,
  input  wire logic       i_sleep_exit,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // port A bits 6 and 7 from the port logic
  input  wire logic       i_port_a_bit_six_out,
  input  wire logic       i_port_a_bit_six_oe,
  input  wire logic       i_port_a_bit_seven_out,
  input  wire logic       i_port_a_bit_seven_oe,
  // oscillator pins
  input  wire logic       i_osc_input_pin,
  input  wire logic       i_osc_output_pin,
  output logic            o_osc_output_pin,
  output logic            o_osc_output_pin_oe,
  output logic            o_osc_input_pin,
  output logic            o_osc_input_pin_oe,
  output logic            o_port_a_bit_six_in,
  output logic            o_port_a_bit_seven_in,
  // clock block controls
  output logic            o_mult_enable,
  output logic            o_xtal_osc_enable,
  output logic            o_ext_clock_select,
  output logic            o_fast_osc_enable,
  output logic            o_slow_osc_enable,
  output logic      [2:0] o_sys_clock_sel,
  output logic      [5:0] o_trim_value,
  output logic            o_startup_wait,
  output logic            o_mode_valid
);

  typedef enum {ST_LATCH, ST_RUN} ocm_phase_type;

  typedef struct packed {
    ocm_phase_type phase;
    logic [3:0]    mode;
    logic [5:0]    trim;
    logic [2:0]    fsel;
    logic [7:0]    rdata;
    logic          pin_out;
    logic          pin_oe;
    logic          in_out;
    logic          in_oe;
    logic          ra6_in;
    logic          ra7_in;
    logic          mult_en;
    logic          xtal_en;
    logic          ext_sel;
    logic          fast_en;
    logic          slow_en;
    logic [2:0]    clk_sel;
    logic          wait_st;
  } ocm_state_type;

  ocm_state_type state;
  ocm_state_type next_state;
  logic          clk_div4;
  logic          div_en;

  // modes with the quarter clock on the output pin
  function automatic logic ocm_has_ckout(input logic [3:0] m);
    return (m == OCM_MODE_EXT_OUT) || (m == OCM_MODE_RC_OUT) || (m == OCM_MODE_INT_CKOUT);
  endfunction : ocm_has_ckout

  // modes that give the output pin to port bit 6
  function automatic logic ocm_out_is_io(input logic [3:0] m);
    return (m == OCM_MODE_EXT_IO) || (m == OCM_MODE_RC_IO) || (m == OCM_MODE_INT_DUAL);
  endfunction : ocm_out_is_io

  // internal block modes, input pin becomes port bit 7
  function automatic logic ocm_is_internal(input logic [3:0] m);
    return (m == OCM_MODE_INT_CKOUT) || (m == OCM_MODE_INT_DUAL);
  endfunction : ocm_is_internal

  // external clock modes
  function automatic logic ocm_is_ext(input logic [3:0] m);
    return (m == OCM_MODE_EXT_OUT) || (m == OCM_MODE_EXT_IO);
  endfunction : ocm_is_ext

  // crystal modes
  function automatic logic ocm_is_xtal(input logic [3:0] m);
    return (m == OCM_MODE_LOW_POWER) || (m == OCM_MODE_CRYSTAL) ||
           (m == OCM_MODE_HS_XTAL) || (m == OCM_MODE_MULT_XTAL);
  endfunction : ocm_is_xtal

  // ten documented encodings
  function automatic logic ocm_valid(input logic [3:0] m);
    return ocm_is_xtal(m) || ocm_has_ckout(m) || ocm_out_is_io(m);
  endfunction : ocm_valid

  assign div_en = ocm_has_ckout(state.mode) && (state.phase == ST_RUN);

  // quarter-rate clock-out
  ocm_div4 u_div4 (
    .i_clk_sys  (i_clk_sys),
    .i_rstn     (i_rstn),
    .i_enable   (div_en),
    .o_clk_div4 (clk_div4)
  );

  // next-state logic
  always_comb begin
    next_state       = state;
    next_state.rdata = 8'h00;
    // mode fixed once after reset release
    if (state.phase == ST_LATCH) begin
      next_state.mode  = i_clock_mode_config;
      next_state.phase = ST_RUN;
    end
    // register writes, no completion flag is kept for trim
    if (i_wr && i_addr == OCM_ADDR_TRIM) begin
      next_state.trim = i_wdata[OCM_TRIM_W-1:0];
    end
    if (i_wr && i_addr == OCM_ADDR_CTRL) begin
      next_state.fsel = i_wdata[OCM_FSEL_LO +: 3];
    end
    // register reads
    if (i_rd) begin
      case (i_addr)
        OCM_ADDR_TRIM:   next_state.rdata = {2'b00, state.trim};
        OCM_ADDR_CTRL:   next_state.rdata = {1'b0, state.fsel, 4'h0};
        OCM_ADDR_STATUS: next_state.rdata = {3'h0, ocm_valid(state.mode), state.mode};
        default:         next_state.rdata = 8'h00;
      endcase
    end
    // clock source controls
    next_state.mult_en = (state.mode == OCM_MODE_MULT_XTAL);
    next_state.xtal_en = ocm_is_xtal(state.mode);
    next_state.ext_sel = ocm_is_ext(state.mode) || (state.mode == OCM_MODE_HS_XTAL);
    // in the latch cycle the mode register still holds its reset value, so decode the strap
    next_state.wait_st = (state.phase == ST_LATCH) ? ocm_is_xtal(i_clock_mode_config) :
                         (ocm_is_xtal(state.mode) && i_sleep_exit);
    next_state.fast_en = ocm_is_internal(state.mode) && (state.fsel != OCM_FSEL_SLOW);
    next_state.slow_en = ocm_is_internal(state.mode) || i_pwrup_timer_en ||
                         i_failsafe_en || i_watchdog_en || i_two_speed_en;
    next_state.clk_sel = state.fsel;
    // output pin
    next_state.pin_out = 1'b0;
    next_state.pin_oe  = 1'b0;
    if (ocm_has_ckout(state.mode)) begin
      next_state.pin_out = clk_div4;
      next_state.pin_oe  = 1'b1;
    end else if (ocm_out_is_io(state.mode)) begin
      next_state.pin_out = i_port_a_bit_six_out;
      next_state.pin_oe  = i_port_a_bit_six_oe;
    end
    next_state.ra6_in = ocm_out_is_io(state.mode) ? i_osc_output_pin : 1'b0;
    // input pin
    next_state.in_out = 1'b0;
    next_state.in_oe  = 1'b0;
    next_state.ra7_in = 1'b0;
    if (ocm_is_internal(state.mode)) begin
      next_state.in_out = i_port_a_bit_seven_out;
      next_state.in_oe  = i_port_a_bit_seven_oe;
      next_state.ra7_in = i_osc_input_pin;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state       <= '0;
      state.phase <= ST_LATCH;
      state.mode  <= OCM_MODE_LOW_POWER;
      state.trim  <= OCM_TRIM_RST;
      state.fsel  <= OCM_FSEL_RST;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops, except mode valid decoded from the mode register
  assign o_rdata               = state.rdata;
  assign o_osc_output_pin      = state.pin_out;
  assign o_osc_output_pin_oe   = state.pin_oe;
  assign o_osc_input_pin       = state.in_out;
  assign o_osc_input_pin_oe    = state.in_oe;
  assign o_port_a_bit_six_in   = state.ra6_in;
  assign o_port_a_bit_seven_in = state.ra7_in;
  assign o_mult_enable         = state.mult_en;
  assign o_xtal_osc_enable     = state.xtal_en;
  assign o_ext_clock_select    = state.ext_sel;
  assign o_fast_osc_enable     = state.fast_en;
  assign o_slow_osc_enable     = state.slow_en;
  assign o_sys_clock_sel       = state.clk_sel;
  assign o_trim_value          = state.trim;
  assign o_startup_wait        = state.wait_st;
  assign o_mode_valid          = ocm_valid(state.mode);

  // mode stays fixed after the latch cycle
  mode_fixed_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $past(state.phase) == ST_RUN |-> $stable(state.mode))
    else $error("clock mode changed after latch");

  mult_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_mult_enable |-> $past(state.mode) == OCM_MODE_MULT_XTAL)
    else $error("multiplier enabled outside multiplied crystal mode");

  ext_nowait_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ocm_is_ext(state.mode) ##1 ocm_is_ext(state.mode) |-> !o_startup_wait)
    else $error("start-up wait in external clock mode");

  // trim write, one idle cycle, then a read shows the written value
  sequence trim_wr_s;
    i_wr && i_addr == OCM_ADDR_TRIM;
  endsequence
  trim_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    trim_wr_s ##1 !i_wr ##1 (i_rd && i_addr == OCM_ADDR_TRIM && !i_wr) |=>
    o_rdata == {2'b00, $past(i_wdata[5:0], 3)})
    else $error("trim read back wrong");

  trim_upper_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $past(i_rd) && $past(i_addr) == OCM_ADDR_TRIM |-> o_rdata[7:6] == 2'b00)
    else $error("trim upper bits not zero");

  fast_en_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ocm_is_internal(state.mode) && state.fsel == OCM_FSEL_FAST |=> o_fast_osc_enable)
    else $error("fast source off while selected");

  slow_en_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_watchdog_en |=> o_slow_osc_enable)
    else $error("slow source off with watchdog enabled");

  ckout_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ocm_has_ckout(state.mode) |=> o_osc_output_pin_oe && o_osc_output_pin == $past(clk_div4))
    else $error("output pin not carrying quarter clock");

  io_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state.mode == OCM_MODE_INT_DUAL |=> o_osc_input_pin_oe == $past(i_port_a_bit_seven_oe))
    else $error("input pin not following port bit 7");

endmodule : ocm_osc_ctrl
`default_nettype wire

/* ocm_ext_src.sv */
// partner model: outside clock source on the oscillator input pin
`timescale 1ns/1ps
`default_nettype none
module ocm_ext_src (
  // clock and control
  input  wire logic i_clk_sys,
  input  wire logic i_run,
  // pin drive
  output logic      o_clk
);
  // toggles every cycle while running, stands still low otherwise
  always_ff @(posedge i_clk_sys) begin
    o_clk <= i_run ? ~o_clk : 1'b0;
  end
endmodule : ocm_ext_src
`default_nettype wire

/* ocm_osc_ctrl_tb.sv */
// self-checking bench for the oscillator mode and internal clock block
`timescale 1ns/1ps
`default_nettype none
module ocm_osc_ctrl_tb
  import ocm_pkg::*;
;
  logic       clk, rstn, wr, rd, sleep_x, run, src, xen, esel;
  logic       six_o, six_oe, sev_o, sev_oe, in_pin, out_pin;
  logic       oo, ooe, io, ioe, six_i, sev_i, mult, fen, sen, sw, mv;
  logic [3:0] cfg, addr, feat;
  logic [7:0] wdata, rdata, s, d;
  logic [2:0] csel;
  logic [5:0] trim;
  logic [9:0] rows [10];
  logic [7:0] tv [4];
  int         mismatches, checks_done, n;

  // released pins show the outside source, toggling while run is set and held low otherwise
  assign in_pin  = ioe ? io : src;
  assign out_pin = ooe ? oo : src;

  ocm_ext_src u_src (.i_clk_sys(clk), .i_run(run), .o_clk(src));

  ocm_osc_ctrl u_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_clock_mode_config(cfg),
    .i_pwrup_timer_en(feat[0]), .i_failsafe_en(feat[1]),
    .i_watchdog_en(feat[2]), .i_two_speed_en(feat[3]), .i_sleep_exit(sleep_x),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_port_a_bit_six_out(six_o), .i_port_a_bit_six_oe(six_oe),
    .i_port_a_bit_seven_out(sev_o), .i_port_a_bit_seven_oe(sev_oe),
    .i_osc_input_pin(in_pin), .i_osc_output_pin(out_pin),
    .o_osc_output_pin(oo), .o_osc_output_pin_oe(ooe),
    .o_osc_input_pin(io), .o_osc_input_pin_oe(ioe),
    .o_port_a_bit_six_in(six_i), .o_port_a_bit_seven_in(sev_i),
    .o_mult_enable(mult), .o_xtal_osc_enable(xen), .o_ext_clock_select(esel),
    .o_fast_osc_enable(fen), .o_slow_osc_enable(sen), .o_sys_clock_sel(csel),
    .o_trim_value(trim), .o_startup_wait(sw), .o_mode_valid(mv));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // reset for ten cycles with a new mode strap, then count start-up wait cycles
  task automatic restart(input logic [3:0] m);
    rstn <= 1'b0;
    cfg <= m;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1 n += int'(sw);
    end
  endtask : restart

  // clock-out must repeat every four cycles, two high and two low
  task automatic clkout_chk;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 s[k] = oo;
    end
    chk("clkout", 8'h01, 8'((s[5:0] ^ s[7:2]) == 6'h3f && s[3:0] == s[7:4]));
    chk("clkout_oe", 8'h01, {7'h0, ooe});
  endtask : clkout_chk

  // port bits drive and read back through the reused pins
  task automatic port_chk(input logic six, input logic sev);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      six_o <= v[0];
      sev_o <= v[0];
      repeat (3) @(posedge clk);
      #1;
      if (six) chk("six", {5'h0, 1'b1, v[0], v[0]}, {5'h0, ooe, oo, six_i});
      if (sev) chk("seven", {5'h0, 1'b1, v[0], v[0]}, {5'h0, ioe, io, sev_i});
      if (!sev) chk("in_oe", 8'h00, {7'h0, ioe});
    end
  endtask : port_chk

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    {rstn, wr, rd, sleep_x, six_o, sev_o, run} = '0;
    {six_oe, sev_oe} = 2'b11;
    {feat, cfg, addr, wdata} = '0;
    mismatches = 0;
    checks_done = 0;
    // mode, then flags: mult, clock-out, bit six, bit seven, outside clock, internal
    rows = '{{OCM_MODE_LOW_POWER, 6'h00}, {OCM_MODE_CRYSTAL, 6'h00},
             {OCM_MODE_HS_XTAL, 6'h00}, {OCM_MODE_EXT_OUT, 6'h12},
             {OCM_MODE_MULT_XTAL, 6'h20}, {OCM_MODE_RC_OUT, 6'h10},
             {OCM_MODE_INT_DUAL, 6'h0d}, {OCM_MODE_INT_CKOUT, 6'h15},
             {OCM_MODE_RC_IO, 6'h08}, {OCM_MODE_EXT_IO, 6'h0a}};
    tv = '{8'hff, 8'h20, 8'h1f, 8'h2a};
    foreach (rows[r]) begin
      run <= rows[r][1] || rows[r][9:6] == OCM_MODE_HS_XTAL;
      restart(rows[r][9:6]);
      chk("mult", {7'h0, rows[r][5]}, {7'h0, mult});
      chk("valid", 8'h01, {7'h0, mv});
      chk("slow", {7'h0, rows[r][0]}, {7'h0, sen});
      chk("fast", 8'h00, {7'h0, fen});
      chk("xtal", 8'(rows[r][9:6] inside {OCM_MODE_LOW_POWER, OCM_MODE_CRYSTAL,
          OCM_MODE_HS_XTAL, OCM_MODE_MULT_XTAL}), {7'h0, xen});
      chk("ext_sel", 8'(rows[r][1] || rows[r][9:6] == OCM_MODE_HS_XTAL), {7'h0, esel});
      if (rows[r][1]) chk("wait", 8'h00, 8'(n));
      rd_reg(OCM_ADDR_STATUS, d);
      chk("status", {4'h1, rows[r][9:6]}, d);
      if (rows[r][4]) clkout_chk();
      port_chk(rows[r][3], rows[r][2]);
    end
    // every frequency select code in an internal mode
    restart(OCM_MODE_INT_DUAL);
    for (int f = 0; f < 8; f++) begin
      wr_reg(OCM_ADDR_CTRL, {1'b0, f[2:0], 4'h0});
      rd_reg(OCM_ADDR_CTRL, d);
      chk("fsel", 8'(f), {5'h0, csel});
      chk("fsel_rd", 8'(f), {5'h0, d[6:4]});
      chk("fast_sel", 8'(f != 0), {7'h0, fen});
      chk("slow_int", 8'h01, {7'h0, sen});
    end
    // trim field, unmapped place, sleep exit in outside clock mode
    run <= 1'b1;
    restart(OCM_MODE_EXT_OUT);
    rd_reg(OCM_ADDR_TRIM, d);
    chk("trim_rst", 8'h00, d);
    foreach (tv[i]) begin
      wr_reg(OCM_ADDR_TRIM, tv[i]);
      rd_reg(OCM_ADDR_TRIM, d);
      chk("trim", tv[i] & 8'h3f, d);
      chk("trim_out", tv[i] & 8'h3f, {2'h0, trim});
    end
    wr_reg(4'hf, 8'h15);
    rd_reg(4'hf, d);
    chk("unmapped", 8'h00, d);
    rd_reg(OCM_ADDR_STATUS, d);
    chk("status_trim", {4'h1, OCM_MODE_EXT_OUT}, d);
    @(posedge clk);
    sleep_x <= 1'b1;
    @(posedge clk);
    sleep_x <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge clk);
      #1 n += int'(sw);
    end
    chk("sleep_wait", 8'h00, 8'(n));
    // trim returns to zero on reset; each special feature wakes the slow source
    restart(OCM_MODE_EXT_OUT);
    rd_reg(OCM_ADDR_TRIM, d);
    chk("trim_rst2", 8'h00, d);
    for (int b = 0; b < 5; b++) begin
      @(posedge clk);
      feat <= (b < 4) ? 4'(1 << b) : 4'h0;
      repeat (3) @(posedge clk);
      #1 chk("slow_feat", 8'(b < 4), {7'h0, sen});
    end
    conclude();
  end
endmodule : ocm_osc_ctrl_tb
`default_nettype wire
